// File: include/pin_irq_pkg.sv
// Package: frame layout, register addresses, field positions and mode codes
package pin_irq_pkg;
	localparam logic [1:0] CMD_WRITE      = 2'b01;
	localparam logic [4:0] ADDR_PIN_MODE  = 5'h11;
	localparam logic [4:0] ADDR_IRQ_EN    = 5'h12;
	localparam logic [7:0] PIN_MODE_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
	localparam int FRAME_CMD_HI  = 15;
	localparam int FRAME_CMD_LO  = 14;
	localparam int FRAME_ADDR_HI = 13;
	localparam int FRAME_ADDR_LO = 9;
	localparam int EN_CAN    = 7;
	localparam int EN_SWREQ  = 6;
	localparam int EN_LIN2   = 5;
	localparam int EN_LIN1   = 4;
	localparam int EN_PIN    = 3;
	localparam int EN_SAFE   = 2;
	localparam int EN_VMON   = 0;
	localparam logic [1:0] MODE_OFF  = 2'b00;
	localparam logic [1:0] MODE_WAKE = 2'b01;
	localparam logic [1:0] MODE_LOW  = 2'b10;
	localparam logic [1:0] MODE_HIGH = 2'b11;
endpackage : pin_irq_pkg

// File: include/cfg_if.sv
// Interface: register write strobes and stored values between top and register bank
`timescale 1ns/1ns
`default_nettype none
interface cfg_if;
	logic       pin_we;
	logic       irq_we;
	logic [7:0] wdata;
	logic [7:0] pin_mode;
	logic [7:0] irq_en;
	modport bank (input pin_we, irq_we, wdata, output pin_mode, irq_en);
	modport ctrl (output pin_we, irq_we, wdata, input pin_mode, irq_en);
endinterface : cfg_if
`default_nettype wire

// File: hdl/cfg_regs.sv
// Register bank holding the pin mode and interrupt enable bytes
`timescale 1ns/1ns
`default_nettype none
module cfg_regs
	import pin_irq_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	cfg_if.bank       cfg
);
	logic [7:0] pin_mode_r;
	logic [7:0] irq_en_r;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_mode_r <= PIN_MODE_RESET;
			irq_en_r   <= IRQ_EN_RESET;
		end else begin
			if (cfg.pin_we)
				pin_mode_r <= cfg.wdata;
			if (cfg.irq_we)
				irq_en_r <= cfg.wdata;
		end
	end

	assign cfg.pin_mode = pin_mode_r;
	assign cfg.irq_en   = irq_en_r;
endmodule : cfg_regs
`default_nettype wire

// File: hdl/pin_and_interrupt_config.sv
// Top: frame decode, wake pin mode decode and gated interrupt output
// Overview of operation
// (RULE1) Frame with command 01 and address 10_001 writes the pin mode byte.
// (RULE2) Frame with command 01 and address 10_010 writes the interrupt enable byte.
// (RULE3) Bits 7:6 set pin three: off, wake sensing, or high-side driver.
// (RULE4) Bits 5:4 set pin two: off, wake sensing, or high-side driver.
// (RULE5) Bits 3:2 set pin one: off, wake, low-side, high-side.
// (RULE6) Bits 1:0 set pin zero: off, wake, low-side, high-side.
// (RULE7) Enable bit 7 lets CAN faults interrupt.
// (RULE8) Bit 6 software request interrupts once per enabling.
// (RULE9) Software request needs both bit 6 and bit 2 set.
// (RULE10) Enable bit 5 lets second LIN faults interrupt.
// (RULE11) Enable bit 4 lets first LIN faults interrupt.
// (RULE12) Enable bit 3 lets wake pin faults interrupt.
// (RULE13) Enable bit 2 lets safety events interrupt.
// (RULE14) Enable bit 0 lets regulator monitoring events interrupt.
// (RULE15) Interrupt output only reflects enabled sources.
`timescale 1ns/1ns
`default_nettype none
module pin_and_interrupt_config
	import pin_irq_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        frame_valid_in,
	input  wire logic [15:0] frame_in,
	input  wire logic        can_fault_in,
	input  wire logic        second_lin_fault_in,
	input  wire logic        first_lin_fault_in,
	input  wire logic        pin_fault_in,
	input  wire logic        safety_fault_in,
	input  wire logic        vmon_fault_in,
	output logic [3:0]       wake_enable_out,
	output logic [3:0]       high_side_driver_out,
	output logic [3:0]       low_side_driver_out,
	output logic [7:0]       pin_mode_out,
	output logic [7:0]       irq_en_out,
	output logic             irq_out
);
	cfg_if cfg ();

	// Both bytes clear to zero at reset
	cfg_regs u_regs (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.cfg        (cfg.bank)
	);

	////////////////////////////////////////////////////////////////////////////
	// Frame decode; the parity/next bit is not checked, so a corrupted frame still lands
	wire [1:0] frame_cmd  = frame_in[FRAME_CMD_HI:FRAME_CMD_LO];
	wire [4:0] frame_addr = frame_in[FRAME_ADDR_HI:FRAME_ADDR_LO];
	wire [7:0] frame_data = frame_in[7:0];

	// Other commands and addresses are dropped with no indication
	function automatic logic hits_register(
		input logic       valid,
		input logic [1:0] cmd,
		input logic [4:0] addr,
		input logic [4:0] reg_addr
	);
		logic cmd_ok;
		logic addr_ok;
		cmd_ok        = (cmd == CMD_WRITE);
		addr_ok       = (addr == reg_addr);
		hits_register = valid && cmd_ok && addr_ok;
	endfunction : hits_register

	wire pin_mode_hit = hits_register(frame_valid_in, frame_cmd, frame_addr, ADDR_PIN_MODE);
	wire irq_en_hit   = hits_register(frame_valid_in, frame_cmd, frame_addr, ADDR_IRQ_EN);

	// One frame writes one whole byte; there is no bit masking
	assign cfg.pin_we = pin_mode_hit; // [RULE1]
	assign cfg.irq_we = irq_en_hit;   // [RULE2]
	assign cfg.wdata  = frame_data;

	////////////////////////////////////////////////////////////////////////////
	// Two-bit field of one pin within the mode byte
	function automatic logic [1:0] pin_field(
		input logic [7:0] modes,
		input logic [1:0] idx
	);
		pin_field = modes[{idx, 1'b0} +: 2];
	endfunction : pin_field

	// Returns {high, low, wake}; pins two and three have no low-side stage, so 10 drives high
	function automatic logic [2:0] decode_mode(
		input logic [1:0] m,
		input logic       has_low
	);
		case (m)
			MODE_OFF:  decode_mode = 3'h0;
			MODE_WAKE: decode_mode = 3'h1;
			MODE_LOW: begin
				if (has_low)
					decode_mode = 3'h2;
				else
					decode_mode = 3'h4;
			end
			MODE_HIGH: decode_mode = 3'h4;
			default:   decode_mode = 3'h0;
		endcase
	endfunction : decode_mode

	// Pins zero and one have both driver stages
	wire [1:0] pin0_code = pin_field(cfg.pin_mode, 2'h0);
	wire [2:0] pin0_dec  = decode_mode(pin0_code, 1'b1); // [RULE6]

	wire [1:0] pin1_code = pin_field(cfg.pin_mode, 2'h1);
	wire [2:0] pin1_dec  = decode_mode(pin1_code, 1'b1); // [RULE5]

	// Pins two and three treat 10 like 11
	wire [1:0] pin2_code = pin_field(cfg.pin_mode, 2'h2);
	wire [2:0] pin2_dec  = decode_mode(pin2_code, 1'b0); // [RULE4]

	wire [1:0] pin3_code = pin_field(cfg.pin_mode, 2'h3);
	wire [2:0] pin3_dec  = decode_mode(pin3_code, 1'b0); // [RULE3]

	wire [3:0] wake_nxt = {pin3_dec[0], pin2_dec[0], pin1_dec[0], pin0_dec[0]};
	wire [3:0] low_nxt  = {pin3_dec[1], pin2_dec[1], pin1_dec[1], pin0_dec[1]};
	wire [3:0] high_nxt = {pin3_dec[2], pin2_dec[2], pin1_dec[2], pin0_dec[2]};

	////////////////////////////////////////////////////////////////////////////
	// Driver enables are registered so a pin never sees a decode glitch
	logic [3:0] wake_r;
	logic [3:0] low_r;
	logic [3:0] high_r;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wake_r <= 4'h0;
		end else begin
			wake_r <= wake_nxt;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			low_r <= 4'h0;
		end else begin
			low_r <= low_nxt;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			high_r <= 4'h0;
		end else begin
			high_r <= high_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register contents are shown straight from the bank
	assign wake_enable_out      = wake_r;
	assign low_side_driver_out  = low_r;
	assign high_side_driver_out = high_r;
	assign pin_mode_out         = cfg.pin_mode;
	assign irq_en_out           = cfg.irq_en;

	////////////////////////////////////////////////////////////////////////////
	// Software request: one pulse when both enables first stand together;
	// a level would hold the interrupt for as long as software leaves the bits set
	wire  sw_req_bit   = cfg.irq_en[EN_SWREQ];
	wire  safe_bit     = cfg.irq_en[EN_SAFE];
	wire  sw_req_armed = sw_req_bit && safe_bit; // [RULE9]
	logic sw_req_seen_r;

	// Delayed copy of the armed level marks its rising edge
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sw_req_seen_r <= 1'b0;
		end else begin
			sw_req_seen_r <= sw_req_armed;
		end
	end

	// Re-arming needs bit 6 or bit 2 cleared and then set again
	wire sw_req_pulse = sw_req_armed && !sw_req_seen_r; // [RULE8]

	////////////////////////////////////////////////////////////////////////////
	// Interrupt gating; masked sources cannot reach the output
	// Source order: CAN, second LIN, first LIN, wake pins, safety, regulator monitor
	function automatic logic [5:0] source_enables(input logic [7:0] en);
		// Bit 1 has no source
		source_enables = {
			en[EN_CAN],  // [RULE7]
			en[EN_LIN2], // [RULE10]
			en[EN_LIN1], // [RULE11]
			en[EN_PIN],  // [RULE12]
			en[EN_SAFE], // [RULE13]
			en[EN_VMON]  // [RULE14]
		};
	endfunction : source_enables

	wire [5:0] fault_vec = {
		can_fault_in,
		second_lin_fault_in,
		first_lin_fault_in,
		pin_fault_in,
		safety_fault_in || sw_req_pulse, // [RULE13]
		vmon_fault_in
	};

	// A fault that clears also clears the output; nothing is latched here
	wire [5:0] masked_vec = fault_vec & source_enables(cfg.irq_en);

	logic irq_r;
	wire  irq_nxt = |masked_vec; // [RULE15]

	// Registered so the output never glitches while enables change
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign irq_out = irq_r;
endmodule : pin_and_interrupt_config
`default_nettype wire

// File: sim/cfg_chk_properties.sv
// Checker of port relations of the pin mode and interrupt block
`timescale 1ns/1ns
`default_nettype none
module cfg_chk
	import pin_irq_pkg::*;
(
	input wire logic        clk_in, sys_rst_in, frame_valid_in, irq_out, can_fault_in,
	input wire logic        second_lin_fault_in, first_lin_fault_in, pin_fault_in,
	input wire logic        safety_fault_in, vmon_fault_in,
	input wire logic [15:0] frame_in,
	input wire logic [3:0]  wake_enable_out, high_side_driver_out, low_side_driver_out,
	input wire logic [7:0]  pin_mode_out, irq_en_out
);
	logic [7:0] pm_r;
	wire logic  sw = irq_en_out[EN_SWREQ] & irq_en_out[EN_SAFE];
	wire logic  en = |({can_fault_in, second_lin_fault_in, first_lin_fault_in, pin_fault_in,
		safety_fault_in, vmon_fault_in} & {irq_en_out[7], irq_en_out[5:2], irq_en_out[0]});
	function automatic logic [3:0] dec(logic [7:0] m, logic [1:0] c);
		for (int i = 0; i < 4; i++) dec[i] = m[2*i+:2] == c;
	endfunction : dec
	// Pin outputs lag the register by one cycle, so compare against a delayed copy
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) pm_r <= 8'h00;
		else pm_r <= pin_mode_out;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_pw; frame_valid_in && frame_in[15:9] == {CMD_WRITE, ADDR_PIN_MODE}
		|=> pin_mode_out == $past(frame_in[7:0]); endproperty
	a_pw: assert property (p_pw) else $error("pin mode write lost");
	property p_iw; frame_valid_in && frame_in[15:9] == {CMD_WRITE, ADDR_IRQ_EN}
		|=> irq_en_out == $past(frame_in[7:0]); endproperty
	a_iw: assert property (p_iw) else $error("enable write lost");
	property p_high; high_side_driver_out == (dec(pm_r, MODE_HIGH) | {pm_r[7], pm_r[5], 2'b00});
	endproperty
	a_high: assert property (p_high) else $error("high side");
	property p_low; low_side_driver_out == (dec(pm_r, MODE_LOW) & 4'h3); endproperty
	a_low: assert property (p_low) else $error("low side");
	property p_wk; wake_enable_out == dec(pm_r, MODE_WAKE); endproperty
	a_wk: assert property (p_wk) else $error("wake");
	property p_on; $past(en) |-> irq_out; endproperty
	a_on: assert property (p_on) else $error("fault lost");
	property p_sw; $past(sw) && !$past(sw, 2) |-> irq_out; endproperty
	a_sw: assert property (p_sw) else $error("request lost");
	property p_off; !$past(en) && !($past(sw) && !$past(sw, 2)) |-> !irq_out; endproperty
	a_off: assert property (p_off) else $error("stray interrupt");
endmodule : cfg_chk
bind pin_and_interrupt_config cfg_chk chk (.*);
`default_nettype wire

// File: sim/mcu_model.sv
// Frame source standing in for the controlling processor
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
	input  wire logic   clk_in,
	output logic        valid_out = 1'b0,
	output logic [15:0] frame_out = 16'h0000
);
	// Released frame shows inverted data so stale bits cannot pass for a match
	task send(input logic [15:0] f);
		valid_out = 1'b1;
		frame_out = f;
		@(negedge clk_in);
		valid_out = 1'b0;
		frame_out = ~f;
	endtask : send
endmodule : mcu_model
`default_nettype wire

// File: sim/testbench.sv
// Testbench: register writes, pin decode and interrupt gating
`timescale 1ns/1ns
`default_nettype none
module testbench
	import pin_irq_pkg::*;
;
	typedef struct {logic [15:0] f; logic [7:0] pm, ie; logic [3:0] wk, hi, lo;} row_s;
	logic        clk_in = 0, sys_rst_in = 1, fv, irq;
	logic [15:0] fr;
	logic [5:0]  flt = 6'h00;
	logic [3:0]  wk, hi_drv, lo_drv;
	logic [7:0]  pm, ie;
	int          err_count = 0, checked = 0;
	// Parity set in row 2; row 3 has command 00 and must change nothing
	row_s rows[4] = '{'{16'h62e4, 8'he4, 8'h00, 4'h2, 4'hc, 4'h0},
		'{16'h631b, 8'h1b, 8'h00, 4'h4, 4'h1, 4'h2}, '{16'h22ff, 8'h1b, 8'h00, 4'h4, 4'h1, 4'h2},
		'{16'h64bd, 8'h1b, 8'hbd, 4'h4, 4'h1, 4'h2}};
	mcu_model mcu (.clk_in(clk_in), .valid_out(fv), .frame_out(fr));
	pin_and_interrupt_config DUT (.clk_in, .sys_rst_in, .frame_valid_in(fv), .frame_in(fr),
		.can_fault_in(flt[5]), .second_lin_fault_in(flt[4]), .first_lin_fault_in(flt[3]),
		.pin_fault_in(flt[2]), .safety_fault_in(flt[1]), .vmon_fault_in(flt[0]),
		.wake_enable_out(wk), .high_side_driver_out(hi_drv), .low_side_driver_out(lo_drv),
		.pin_mode_out(pm), .irq_en_out(ie), .irq_out(irq));
	initial forever #2 clk_in = ~clk_in;
	task chk(input logic [7:0] g, e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// Run needs about 32 cycles; 5000 leaves ample margin
	initial begin
		#20000;
		err_count++;
		conclude;
	end
	initial begin
		repeat (8) @(negedge clk_in);
		sys_rst_in = 0;
		chk(pm, 8'h00);
		chk(ie, 8'h00);
		foreach (rows[i]) begin
			mcu.send(rows[i].f);
			@(negedge clk_in);
			chk(pm, rows[i].pm);
			chk(ie, rows[i].ie);
			chk(wk, rows[i].wk);
			chk(hi_drv, rows[i].hi);
			chk(lo_drv, rows[i].lo);
		end
		$display("register rows done");
		for (int i = 0; i < 6; i++) begin
			flt = 6'h01 << i;
			@(negedge clk_in);
			chk(irq, 8'h01);
		end
		flt = 6'h00;
		mcu.send(16'h6400);
		@(negedge clk_in);
		mcu.send(16'h6444);
		@(negedge clk_in);
		chk(irq, 8'h01);
		@(negedge clk_in);
		chk(irq, 8'h00);
		mcu.send(16'h6440);
		flt = 6'h3f;
		repeat (2) @(negedge clk_in);
		chk(irq, 8'h00);
		sys_rst_in = 1;
		@(negedge clk_in);
		chk(pm, 8'h00);
		chk(ie, 8'h00);
		sys_rst_in = 0;
		@(negedge clk_in);
		chk(irq, 8'h00);
		$display("interrupt and reset tests done");
		conclude;
	end
endmodule : testbench
`default_nettype wire
